// File: design/cable_power_switch_fault_ctrl.sv
// cable power switch sequencing, short check and fault handling
// Function
// [RULE1] low overcurrent limit 50-500mA, 400us debounce
// [RULE2] fixed 750mA overcurrent limit, 5us debounce
// [RULE3] host programs limits, orientation, then enables
// [RULE4] undervoltage level select, 3.05V after reset
// [RULE5] diag current, pin ok, soft-start, present flag
// [RULE6] short check on every start and restart
// [RULE7] short seen: 8ms diag window, rise proceeds
// [RULE8] window fails: 16ms off, then check again
// [RULE9] reverse overvoltage opens switch, flag while present
// [RULE10] reverse overvoltage cleared: restart after retry interval
// [RULE11] only overcurrent and undervoltage are retried
// [RULE12] three consecutive faults drive alert low
// [RULE13] overcurrent: third fault latches, retry, shield flag
// [RULE14] host clears latched overcurrent flag, then disables
// [RULE15] overcurrent detect disable suppresses overcurrent faults
// [RULE16] undervoltage opens switch, restarts through startup
// [RULE17] third undervoltage sets flag, retry, counter reset
// [RULE18] disable bit hides only undervoltage reporting; code masks it with oc_dis, which also suppresses overcurrent faults
// [RULE19] every disable discharges pin for 1ms; a disable while still in ST_IDLE gives no discharge
// [RULE20] fault counter clears on disable or clean start
`timescale 1ns/10ps
`include "cps_params.svh"
module cable_power_switch_fault_ctrl #(
  parameter int unsigned OCL_DEB_CYC = `CPS_OCL_DEB_CYC,
  parameter int unsigned SS_DIAG_CYC = `CPS_SS_DIAG_CYC,
  parameter int unsigned MS_CYC = `CPS_MS_CYC
)
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // monitors
  input wire logic [9:0] load_current_ma,
  input wire logic [1:0] cc_above_stg,
  input wire logic supply_below_high,
  input wire logic supply_below_low,
  input wire logic reverse_ov,
  // per-channel drives, bit 0 is the first protected_cc_pin
  output logic [1:0] switch_on,
  output logic [1:0] diag_current_on,
  output logic [1:0] discharge_on,
  output logic alert_n
);
  import cps_pkg::*;

  cps_regs_type cur;
  cps_regs_type nx;
  logic tick;
  logic switch_closed;
  logic over_low;
  logic over_high;
  logic ocl_fault;
  logic och_fault;
  logic oc_fault;
  logic uv_now;
  logic cc_ok;
  logic [7:0] status_byte;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [9:0] ocl_ma(input logic [3:0] sel);
    logic [9:0] ma;
    ma = 10'({6'h00, sel} + 10'h001) * `CPS_OCL_STEP_MA;
    // codes above the top step saturate
    if (sel > 4'h9)
    begin
      ma = `CPS_OCL_MAX_MA;
    end
    return ma;
  endfunction

  function automatic logic [1:0] chan_sel(input logic chan, input logic on);
    return on ? (chan ? 2'b10 : 2'b01) : 2'b00;
  endfunction

  // ****************************************************************
  // monitors and debounce
  // ****************************************************************
  assign switch_closed = (cur.state == ST_SOFTSTART) || (cur.state == ST_ON);
  assign over_low = load_current_ma > ocl_ma(cur.ocl_sel); // RULE1
  assign over_high = load_current_ma > `CPS_OCH_LIMIT_MA; // RULE2
  assign uv_now = cur.uv_sel ? supply_below_high : supply_below_low; // RULE4
  assign cc_ok = cc_above_stg[cur.chan];
  assign oc_fault = (ocl_fault || och_fault) && !cur.oc_dis; // RULE15

  ocp_debounce #(
    .CYCLES(OCL_DEB_CYC)
  ) low_debounce (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .level(switch_closed && !cur.oc_dis && over_low), // RULE1
    .fault(ocl_fault)
  );

  ocp_debounce #(
    .CYCLES(`CPS_OCH_DEB_CYC)
  ) high_debounce (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .level(switch_closed && !cur.oc_dis && over_high), // RULE2
    .fault(och_fault)
  );

  // ****************************************************************
  // registers and sequencer
  // ****************************************************************
  always_comb
  begin
    status_byte = '0;
    status_byte[`CPS_ST_PRESENT] = cur.present;
    status_byte[`CPS_ST_UV] = cur.uv_flag && !cur.oc_dis; // RULE18
    status_byte[`CPS_ST_ROV] = cur.rov_flag;
    status_byte[`CPS_ST_OC] = cur.oc_latched;
    status_byte[`CPS_ST_SHIELD] = cur.shield;
    status_byte[`CPS_ST_ALERT] = cur.alert;
    status_byte[`CPS_ST_SUPPLY_LOW] = uv_now;
  end

  always_comb
  begin
    nx = cur;
    tick = cur.cyc == 15'(MS_CYC - 1);
    nx.cyc = tick ? 15'h0000 : cur.cyc + 15'h0001;
    if (tick)
    begin
      nx.ms = cur.ms + 8'h01;
    end
    nx.rov_flag = reverse_ov; // RULE9
    if (!uv_now)
    begin
      nx.uv_flag = 1'b0;
    end
    // software clears go first so a same-cycle hardware set wins
    if (reg_write)
    begin
      case (reg_addr)
        `CPS_ADDR_CONTROL:
        begin
          nx.enable = reg_wdata[`CPS_CTRL_ENABLE];
          nx.orient = reg_wdata[`CPS_CTRL_ORIENT];
          nx.uv_sel = reg_wdata[`CPS_CTRL_UV_SEL];
          nx.oc_dis = reg_wdata[`CPS_CTRL_OC_DIS];
        end
        `CPS_ADDR_OCL: nx.ocl_sel = reg_wdata[3:0];
        `CPS_ADDR_RETRY: nx.retry = reg_wdata;
        `CPS_ADDR_STATUS:
        begin
          nx.oc_latched = cur.oc_latched && !reg_wdata[`CPS_ST_OC]; // RULE14
          nx.shield = cur.shield && !reg_wdata[`CPS_ST_SHIELD];
          nx.alert = cur.alert && !reg_wdata[`CPS_ST_ALERT];
        end
        default:
        begin
        end
      endcase
    end
    nx.rdata = 8'h00;
    if (reg_read)
    begin
      case (reg_addr)
        `CPS_ADDR_CONTROL: nx.rdata = {4'h0, cur.oc_dis, cur.uv_sel, cur.orient, cur.enable};
        `CPS_ADDR_OCL: nx.rdata = {4'h0, cur.ocl_sel};
        `CPS_ADDR_RETRY: nx.rdata = cur.retry;
        `CPS_ADDR_STATUS: nx.rdata = status_byte;
        `CPS_ADDR_DIAG: nx.rdata = {cur.state, 2'b00, cur.fcount};
        default: nx.rdata = 8'h00;
      endcase
    end
    case (cur.state)
      ST_IDLE:
      begin
        nx.fcount = 2'h0; // RULE20
        if (cur.enable && !uv_now)
        begin
          nx.chan = cur.orient;
          nx.state = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        if (!uv_now && cc_ok)
        begin
          nx.state = ST_SOFTSTART; // RULE5 RULE6
        end
        else if (!uv_now)
        begin
          nx.state = ST_STG_WINDOW; // RULE7
        end
      end
      ST_STG_WINDOW:
      begin
        if (cc_ok)
        begin
          nx.state = ST_SOFTSTART; // RULE7
        end
        else if (cur.ms == `CPS_STG_WINDOW_MS)
        begin
          nx.state = ST_STG_WAIT; // RULE8
        end
      end
      ST_STG_WAIT:
      begin
        if (cur.ms == `CPS_STG_WAIT_MS)
        begin
          nx.state = ST_CHECK; // RULE8
        end
      end
      ST_SOFTSTART, ST_ON:
      begin
        if (reverse_ov)
        begin
          // not a retried fault, counter left alone
          nx.state = ST_REV_OV; // RULE9 RULE11
        end
        else if (oc_fault || uv_now)
        begin
          nx.cause_oc = oc_fault;
          nx.cause_rov = 1'b0;
          if (cur.fcount == `CPS_FAULT_LIMIT - 2'h1)
          begin
            nx.fcount = `CPS_FAULT_LIMIT;
            nx.alert = 1'b1; // RULE12
            nx.oc_latched = nx.oc_latched || oc_fault; // RULE13
            nx.uv_flag = !oc_fault || nx.uv_flag; // RULE17
            nx.state = ST_RETRY_WAIT;
          end
          else
          begin
            nx.fcount = cur.fcount + 2'h1; // RULE11
            nx.state = ST_CHECK; // RULE13 RULE16
          end
        end
        else if (cur.state == ST_SOFTSTART && cur.cyc == 15'(SS_DIAG_CYC - 1))
        begin
          nx.fcount = 2'h0; // RULE20
          nx.state = ST_ON; // RULE5
        end
      end
      ST_REV_OV:
      begin
        if (!reverse_ov)
        begin
          nx.cause_rov = 1'b1;
          nx.state = ST_RETRY_WAIT; // RULE10
        end
      end
      ST_RETRY_WAIT:
      begin
        if (cur.ms >= cur.retry)
        begin
          if (!cur.cause_rov)
          begin
            nx.fcount = 2'h0; // RULE17
            nx.shield = cur.cause_oc || nx.shield; // RULE13
          end
          nx.state = ST_CHECK; // RULE6 RULE10
        end
      end
      ST_DISCHARGE:
      begin
        if (cur.ms == `CPS_DISCHARGE_MS)
        begin
          nx.state = ST_IDLE;
        end
      end
      default: nx.state = ST_IDLE;
    endcase
    // disable wins over every sequence step
    if (!cur.enable && cur.state != ST_IDLE && cur.state != ST_DISCHARGE)
    begin
      nx.fcount = 2'h0; // RULE20
      nx.state = ST_DISCHARGE; // RULE19
    end
    nx.present = nx.state == ST_ON; // RULE5
    if (nx.state != cur.state)
    begin
      nx.cyc = 15'h0000;
      nx.ms = 8'h00;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cur <= '0;
      cur.state <= ST_IDLE;
      {cur.oc_dis, cur.uv_sel, cur.orient, cur.enable} <= `CPS_CONTROL_RESET; // RULE4
      cur.ocl_sel <= `CPS_OCL_RESET;
      cur.retry <= `CPS_RETRY_RESET;
    end
    else if (clk_en)
    begin
      cur <= nx;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign switch_on = chan_sel(cur.chan, switch_closed); // RULE6
  assign diag_current_on = chan_sel(cur.chan, cur.state == ST_CHECK ||
    cur.state == ST_STG_WINDOW || cur.state == ST_SOFTSTART || cur.state == ST_REV_OV);
  assign discharge_on = chan_sel(cur.chan, cur.state == ST_DISCHARGE); // RULE19
  assign alert_n = !cur.alert; // RULE12
  assign reg_rdata = cur.rdata;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_third_fault;
    clk_en && cur.enable && switch_closed && !reverse_ov && (oc_fault || uv_now) &&
      cur.fcount == 2'h2;
  endsequence

  sequence s_open_wait;
    switch_on == 2'b00 && cur.state == ST_RETRY_WAIT;
  endsequence

  property p_third_fault;
    s_third_fault |=> s_open_wait ##0 !alert_n;
  endproperty
  a_third_fault: assert property (p_third_fault) else $error("no alert on third fault"); // RULE12

  property p_oc_latch;
    s_third_fault ##0 oc_fault |=> cur.oc_latched && cur.cause_oc;
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("oc flag not latched"); // RULE13

  property p_rov_open;
    clk_en && reverse_ov && switch_closed && cur.enable |=>
      switch_on == 2'b00 && diag_current_on != 2'b00 && cur.rov_flag && $stable(cur.fcount);
  endproperty
  a_rov_open: assert property (p_rov_open) else $error("reverse ov not handled"); // RULE9

  property p_uv_default;
    $fell(reset) |-> !cur.uv_sel;
  endproperty
  a_uv_default: assert property (p_uv_default) else $error("uv level not low after reset"); // RULE4

  property p_softstart;
    cur.state == ST_SOFTSTART |-> switch_on != 2'b00 && diag_current_on == switch_on;
  endproperty
  a_softstart: assert property (p_softstart) else $error("soft-start drive wrong"); // RULE5

  property p_stg_wait;
    cur.state == ST_STG_WAIT |-> switch_on == 2'b00 && diag_current_on == 2'b00;
  endproperty
  a_stg_wait: assert property (p_stg_wait) else $error("drive during short wait"); // RULE8

  property p_no_switch_on_short;
    clk_en && cur.state == ST_CHECK && !cc_ok |=> switch_on == 2'b00;
  endproperty
  a_no_switch_on_short: assert property (p_no_switch_on_short) else $error("switch on short"); // RULE6

  property p_oc_disable;
    clk_en && cur.oc_dis |=> !ocl_fault && !och_fault;
  endproperty
  a_oc_disable: assert property (p_oc_disable) else $error("oc fault while disabled"); // RULE15

  property p_discharge;
    clk_en && !cur.enable && switch_closed |=> discharge_on != 2'b00 && cur.fcount == 2'h0;
  endproperty
  a_discharge: assert property (p_discharge) else $error("no discharge on disable"); // RULE19

  property p_clean_start;
    clk_en && cur.state == ST_SOFTSTART && nx.state == ST_ON |=> cur.fcount == 2'h0 && cur.present;
  endproperty
  a_clean_start: assert property (p_clean_start) else $error("counter not cleared"); // RULE20

endmodule

// File: design/cps_params.svh
// constants for the cable power switch fault controller
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CPS_CLK_MHZ 25
`define CPS_OCL_DEB_US 400
`define CPS_OCL_DEB_CYC (`CPS_OCL_DEB_US * `CPS_CLK_MHZ)
`define CPS_OCH_DEB_NS 5000
`define CPS_OCH_DEB_CYC (`CPS_OCH_DEB_NS * `CPS_CLK_MHZ / 1000)
`define CPS_SS_DIAG_US 500
`define CPS_SS_DIAG_CYC (`CPS_SS_DIAG_US * `CPS_CLK_MHZ)
`define CPS_MS_CYC (1000 * `CPS_CLK_MHZ)
`define CPS_STG_WINDOW_MS 8'h08
`define CPS_STG_WAIT_MS 8'h10
`define CPS_DISCHARGE_MS 8'h01
`define CPS_FAULT_LIMIT 2'h3

// ****************************************************************
// current thresholds in mA
// ****************************************************************
`define CPS_OCH_LIMIT_MA 10'h2ee
`define CPS_OCL_STEP_MA 10'h032
`define CPS_OCL_MAX_MA 10'h1f4

// ****************************************************************
// register offsets
// ****************************************************************
`define CPS_ADDR_CONTROL 4'h0
`define CPS_ADDR_OCL 4'h1
`define CPS_ADDR_RETRY 4'h2
`define CPS_ADDR_STATUS 4'h3
`define CPS_ADDR_DIAG 4'h4

// ****************************************************************
// field positions
// ****************************************************************
`define CPS_CTRL_ENABLE 0
`define CPS_CTRL_ORIENT 1
`define CPS_CTRL_UV_SEL 2
`define CPS_CTRL_OC_DIS 3
`define CPS_ST_PRESENT 0
`define CPS_ST_UV 1
`define CPS_ST_ROV 2
`define CPS_ST_OC 3
`define CPS_ST_SHIELD 4
`define CPS_ST_ALERT 5
`define CPS_ST_SUPPLY_LOW 6

// ****************************************************************
// reset values
// ****************************************************************
`define CPS_CONTROL_RESET 4'h0
`define CPS_OCL_RESET 4'h0
`define CPS_RETRY_RESET 8'h10

`endif

// File: design/cps_pkg.sv
// types shared by the cable power switch fault controller
package cps_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CHECK = 4'b0001,
    ST_STG_WINDOW = 4'b0010,
    ST_STG_WAIT = 4'b0011,
    ST_SOFTSTART = 4'b0100,
    ST_ON = 4'b0101,
    ST_REV_OV = 4'b0110,
    ST_RETRY_WAIT = 4'b0111,
    ST_DISCHARGE = 4'b1000
  } cps_state_type;

  typedef struct packed {
    cps_state_type state;
    logic chan;
    logic [14:0] cyc;
    logic [7:0] ms;
    logic [1:0] fcount;
    logic cause_oc;
    logic cause_rov;
    logic enable;
    logic orient;
    logic uv_sel;
    logic oc_dis;
    logic [3:0] ocl_sel;
    logic [7:0] retry;
    logic present;
    logic uv_flag;
    logic rov_flag;
    logic oc_latched;
    logic shield;
    logic alert;
    logic [7:0] rdata;
  } cps_regs_type;

  typedef struct packed {
    logic [13:0] count;
    logic fault;
  } debounce_regs_type;

endpackage

// File: design/ocp_debounce.sv
// debounce of one overcurrent comparator level
`timescale 1ns/10ps
module ocp_debounce #(
  parameter int unsigned CYCLES = 125
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // level in, fault pulse out
  input wire logic level,
  output logic fault
);
  import cps_pkg::*;

  debounce_regs_type cur;
  debounce_regs_type nx;

  always_comb
  begin
    nx = cur;
    nx.fault = 1'b0;
    if (!level)
    begin
      nx.count = '0;
    end
    else if (cur.count == 14'(CYCLES - 1))
    begin
      // restart so a held excess keeps reporting every period
      nx.count = '0;
      nx.fault = 1'b1;
    end
    else
    begin
      nx.count = cur.count + 14'h0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cur <= '0;
    end
    else if (clk_en)
    begin
      cur <= nx;
    end
  end

  assign fault = cur.fault;

endmodule

// File: tb/cable_load_model.sv
// far side model: protected pin comparators and powered cable load
`timescale 1ns/10ps
module cable_load_model
(
  // drives from the controller
  input wire logic [1:0] switch_on,
  input wire logic [1:0] diag_current_on,
  // scenario controls
  input wire logic [1:0] short_gnd,
  input wire logic [9:0] load_ma,
  // monitors back to the controller
  output logic [1:0] cc_above_stg,
  output logic [9:0] load_current_ma
);
  // an unsourced pin sinks through the cable pull-down, so it never reads high
  assign cc_above_stg = (switch_on | diag_current_on) & ~short_gnd;
  // diag current is too small to count as load
  assign load_current_ma = (|switch_on) ? load_ma : 10'h000;
endmodule

// File: tb/tb_cable_power_switch_fault_ctrl.sv
// self-checking bench for the cable power switch fault controller
`timescale 1ns/10ps
`include "cps_params.svh"
module tb_cable_power_switch_fault_ctrl;
  import cps_pkg::*;
  localparam int MS = 400;
  logic ref_clk, reset, clk_en, reg_write, reg_read, alert_n;
  logic supply_below_high, supply_below_low, reverse_ov;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [9:0] load_current_ma, load_ma;
  logic [1:0] cc_above_stg, switch_on, diag_current_on, discharge_on, short_gnd;
  int failures = 0;
  int samples_checked = 0;
  int n;
  // rows: address, value written, value read back
  logic [3:0] row_addr [4] = '{4'h1, 4'h2, 4'h0, 4'h7};
  logic [7:0] row_wdata [4] = '{8'h09, 8'h0a, 8'h0e, 8'h55};
  logic [7:0] row_rdata [4] = '{8'h09, 8'h0a, 8'h0e, 8'h00};

  // short counts keep the run near 15k cycles; 1 ms is MS cycles
  // low debounce kept above the 125-cycle high one so both limits are seen apart
  cable_power_switch_fault_ctrl #(.OCL_DEB_CYC(200), .SS_DIAG_CYC(200), .MS_CYC(MS)) DUT (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .load_current_ma(load_current_ma), .cc_above_stg(cc_above_stg),
    .supply_below_high(supply_below_high), .supply_below_low(supply_below_low),
    .reverse_ov(reverse_ov), .switch_on(switch_on), .diag_current_on(diag_current_on),
    .discharge_on(discharge_on), .alert_n(alert_n));

  cable_load_model far_side (
    .switch_on(switch_on), .diag_current_on(diag_current_on), .short_gnd(short_gnd),
    .load_ma(load_ma), .cc_above_stg(cc_above_stg), .load_current_ma(load_current_ma));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic rng(input int c, input int lo, input int hi);
    chk(16'((c >= lo && c <= hi) ? lo : c), 16'(lo));
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  function automatic logic [1:0] drv(input int sel);
    return sel == 0 ? switch_on : (sel == 1 ? diag_current_on : discharge_on);
  endfunction

  // bounded wait for a drive pattern; n holds the cycles taken
  task automatic wt(input int sel, input logic [1:0] w, input int mx);
    #1;
    n = 0;
    while (drv(sel) !== w && n < mx)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(drv(sel), w);
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial
  begin
    #(40 * 50000);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    load_ma = 10'h000;
    short_gnd = 2'b00;
    supply_below_high = 1'b0;
    supply_below_low = 1'b0;
    reverse_ov = 1'b0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(`CPS_ADDR_CONTROL);
    chk(v, 8'h00);
    rd(`CPS_ADDR_RETRY);
    chk(v, 8'h10);
    rd(`CPS_ADDR_OCL);
    chk(v, 8'h00);
    chk({discharge_on, switch_on, alert_n}, 5'h01);
    for (int i = 0; i < 4; i++)
    begin
      wr(row_addr[i], row_wdata[i]);
      rd(row_addr[i]);
      chk(v, row_rdata[i]);
    end
    // start-up: limit 100 mA, retry 1 ms, supply check, channel 1
    wr(`CPS_ADDR_OCL, 8'h01);
    wr(`CPS_ADDR_RETRY, 8'h01);
    rd(`CPS_ADDR_STATUS);
    chk(v, 8'h00);
    load_ma <= 10'h064;
    wr(`CPS_ADDR_CONTROL, 8'h03);
    wt(0, 2'b10, 5);
    chk(diag_current_on, 2'b10);
    wt(1, 2'b00, 250);
    rng(n, 195, 202);
    chk(switch_on, 2'b10);
    rd(`CPS_ADDR_STATUS);
    chk(v, 8'h01);
    // one mA above the low limit
    load_ma <= 10'h065;
    wt(0, 2'b00, 250);
    rng(n, 199, 204);
    rd(`CPS_ADDR_DIAG);
    chk(v & 8'h03, 8'h01);
    load_ma <= 10'h000;
    wt(0, 2'b10, 10);
    wt(1, 2'b00, 250);
    rd(`CPS_ADDR_DIAG);
    chk(v, 8'h50);
    // 800 mA: ignored while detection is off, then three fast trips
    wr(`CPS_ADDR_CONTROL, 8'h0b);
    load_ma <= 10'h320;
    repeat (300) @(posedge ref_clk);
    #1;
    chk(switch_on, 2'b10);
    wr(`CPS_ADDR_CONTROL, 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      wt(0, 2'b10, 10);
      wt(0, 2'b00, 200);
      if (i > 0)
        rng(n, 123, 130);
    end
    rd(`CPS_ADDR_STATUS);
    chk(v & 8'h38, 8'h28);
    chk(alert_n, 1'b0);
    load_ma <= 10'h000;
    wt(0, 2'b10, MS + 20);
    rng(n, MS - 8, MS + 8);
    wt(1, 2'b00, 250);
    rd(`CPS_ADDR_STATUS);
    chk(v, 8'h39);
    wr(`CPS_ADDR_STATUS, 8'h38);
    rd(`CPS_ADDR_STATUS);
    chk(v, 8'h01);
    chk(alert_n, 1'b1);
    wr(`CPS_ADDR_CONTROL, 8'h02);
    wt(2, 2'b10, 5);
    wt(2, 2'b00, MS + 20);
    rng(n, MS - 3, MS + 3);
    rd(`CPS_ADDR_DIAG);
    chk(v, 8'h00);
    // shorted channel 0; the high supply comparator alone must not trip
    supply_below_high <= 1'b1;
    short_gnd <= 2'b01;
    wr(`CPS_ADDR_CONTROL, 8'h01);
    wt(1, 2'b01, 5);
    wt(1, 2'b00, 8 * MS + 100);
    rng(n, 8 * MS - 3, 8 * MS + 3);
    chk(switch_on, 2'b00);
    wt(1, 2'b01, 16 * MS + 100);
    rng(n, 16 * MS - 3, 16 * MS + 3);
    repeat (100) @(posedge ref_clk);
    short_gnd <= 2'b00;
    wt(0, 2'b01, 5);
    wt(1, 2'b00, 250);
    // reverse overvoltage in the on state
    reverse_ov <= 1'b1;
    wt(0, 2'b00, 3);
    chk(diag_current_on, 2'b01);
    rd(`CPS_ADDR_STATUS);
    chk(v & 8'h04, 8'h04);
    reverse_ov <= 1'b0;
    wt(0, 2'b01, MS + 20);
    rng(n, MS - 5, MS + 8);
    rd(`CPS_ADDR_DIAG);
    chk(v & 8'h03, 8'h00);
    wt(1, 2'b00, 250);
    // three undervoltage trips, the last one held
    for (int i = 0; i < 3; i++)
    begin
      wt(0, 2'b01, MS + 20);
      supply_below_low <= 1'b1;
      wt(0, 2'b00, 4);
      if (i < 2)
        supply_below_low <= 1'b0;
    end
    rd(`CPS_ADDR_STATUS);
    chk(v & 8'h62, 8'h62);
    chk(alert_n, 1'b0);
    wr(`CPS_ADDR_CONTROL, 8'h09);
    rd(`CPS_ADDR_STATUS);
    chk(v & 8'h62, 8'h60);
    supply_below_low <= 1'b0;
    wt(0, 2'b01, MS + 20);
    wr(`CPS_ADDR_CONTROL, 8'h05);
    wt(0, 2'b00, 4);
    rd(`CPS_ADDR_DIAG);
    chk(v, 8'h11);
    wr(`CPS_ADDR_CONTROL, 8'h00);
    rd(`CPS_ADDR_DIAG);
    chk(v, 8'h80);
    // a low clock enable must hold the discharge past its 1 ms
    clk_en <= 1'b0;
    repeat (MS + 100) @(posedge ref_clk);
    #1;
    chk(discharge_on, 2'b01);
    clk_en <= 1'b1;
    wt(2, 2'b00, MS + 20);
    summarize();
  end
endmodule
